// ### rtl/ssrb_bank.sv
// Safety register bank with challenge-response protected writes.
// Assumes the serial front end hands over whole byte commands on i_cmd,
// and that raw analog fault indications arrive asynchronously.
// How it works
// - Write one clears selftest buck/linear low flags
// - Write one to trigger starts analog selftest
// - Write one clears fail-safe output fault flags
// - Thermal off blocks thermal interrupt and shutdown
// - Lockout off blocks all input overvoltage reporting
// - Shutdown off: overvoltage gives interrupt only
// - Timer off keeps supervisor counter stopped
// - Standby timer off stops counter in standby
// - Standby watch off ignores kick input standby
// - Secure off lets protected writes apply directly
// - Buck monitor bit zero disables its monitoring
// - Linear monitor bit zero disables its monitoring
// - Protected write produces random challenge for host
// - Matching response applies, else discard; clear both
// - Any other command except a challenge read cancels pending protected write
// - No response in 10 ms abandons write
`timescale 1ns/10ps
module ssrb_bank
  import ssrb_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = SECURE_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register command port
  input wire ssrb_cmd_type i_cmd,
  output logic o_rvalid,
  output logic [7:0] o_rdata,
  // Hardware flag sources, asynchronous levels
  input wire logic [BUCK_FLAG_W-1:0] i_selftest_buck_low,
  input wire logic [LINEAR_W-1:0] i_selftest_linear_low,
  input wire logic [FAILSAFE_W-1:0] i_failsafe_fault,
  // Raw monitor conditions, asynchronous levels
  input wire logic i_thermal_alarm,
  input wire logic i_thermal_trip,
  input wire logic i_main_supply_overvolt,
  input wire logic i_standby,
  // Controls to the safety logic
  output logic o_selftest_go,
  output ssrb_events_type o_events,
  output ssrb_enables_type o_enables
);

  // ==========================================================
  // Input synchronisers: three stages, value taken when 2 and 3 agree
  localparam int SYN_W = BUCK_FLAG_W + LINEAR_W + FAILSAFE_W + 4;
  logic [SYN_W-1:0] syn1_r, syn2_r, syn3_r, syn_r, syn_nxt;
  logic [BUCK_FLAG_W-1:0] s_buck;
  logic [LINEAR_W-1:0] s_lin;
  logic [FAILSAFE_W-1:0] s_fs;
  logic s_talarm, s_ttrip, s_ov, s_stby;

  always_comb begin
    syn_nxt = (syn2_r == syn3_r) ? syn3_r : syn_r;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      syn1_r <= '0;
      syn2_r <= '0;
      syn3_r <= '0;
      syn_r <= '0;
    end else begin
      syn1_r <= {i_selftest_buck_low, i_selftest_linear_low, i_failsafe_fault,
                 i_thermal_alarm, i_thermal_trip, i_main_supply_overvolt, i_standby};
      syn2_r <= syn1_r;
      syn3_r <= syn2_r;
      syn_r <= syn_nxt;
    end
  end

  assign {s_buck, s_lin, s_fs, s_talarm, s_ttrip, s_ov, s_stby} = syn_r;

  // ==========================================================
  // Register state
  logic [BUCK_FLAG_W-1:0] buck_flags_r, buck_flags_nxt;
  logic [LINEAR_W-1:0] lin_flags_r, lin_flags_nxt;
  logic [FAILSAFE_W-1:0] fs_flags_r, fs_flags_nxt;
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [BUCK_MON_W-1:0] buck_mon_r, buck_mon_nxt;
  logic [LINEAR_W-1:0] lin_mon_r, lin_mon_nxt;
  logic go_r, go_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  // Secure write state
  ssrb_sec_type sec_r, sec_nxt;
  logic [7:0] chal_r, chal_nxt;
  logic [7:0] pend_addr_r, pend_addr_nxt;
  logic [7:0] pend_data_r, pend_data_nxt;
  logic [TMO_W-1:0] tmo_r, tmo_nxt;
  logic [7:0] lfsr_r, lfsr_nxt;

  // Registers under challenge-response protection
  function automatic logic is_protected(input logic [7:0] a);
    return (a == OFS_BUCK_SELFTEST_UNDERVOLT_FLAGS) ||
           (a == OFS_LINEAR_SELFTEST_UNDERVOLT_FLAGS) ||
           (a == OFS_SELFTEST_TRIGGER) || (a == OFS_SAFE_OUTPUT_FAULT_FLAGS) ||
           (a == OFS_SAFETY_MONITOR_CONTROL) || (a == OFS_BUCK_MONITOR_ENABLES) ||
           (a == OFS_LINEAR_MONITOR_ENABLES);
  endfunction

  logic apply_en;
  logic [7:0] apply_addr;
  logic [7:0] apply_data;
  logic wr, rd;

  assign wr = i_cmd.valid && i_cmd.write;
  assign rd = i_cmd.valid && !i_cmd.write;

  // ==========================================================
  // Secure write sequencer
  always_comb begin
    sec_nxt = sec_r;
    chal_nxt = chal_r;
    pend_addr_nxt = pend_addr_r;
    pend_data_nxt = pend_data_r;
    tmo_nxt = tmo_r;
    apply_en = 1'b0;
    apply_addr = i_cmd.addr;
    apply_data = i_cmd.data;
    // Free-running so the code depends on host timing
    lfsr_nxt = lfsr_r[0] ? ((lfsr_r >> 1) ^ LFSR_TAPS) : (lfsr_r >> 1);
    case (sec_r)
      SEC_IDLE: begin
        if (wr && is_protected(i_cmd.addr)) begin
          if (ctrl_r[CTL_SECURE_BIT]) begin
            sec_nxt = SEC_WAIT;
            chal_nxt = lfsr_r;
            pend_addr_nxt = i_cmd.addr;
            pend_data_nxt = i_cmd.data;
            tmo_nxt = '0;
          end else begin
            apply_en = 1'b1;
          end
        end
      end
      SEC_WAIT: begin
        tmo_nxt = tmo_r + 1'b1;
        if (wr && i_cmd.addr == OFS_CHALLENGE_RESPONSE) begin
          apply_en = (i_cmd.data == chal_r);
          apply_addr = pend_addr_r;
          apply_data = pend_data_r;
          sec_nxt = SEC_IDLE;
          chal_nxt = '0;
        end else if (wr && is_protected(i_cmd.addr)) begin
          // A new protected write replaces the pending one with a fresh challenge
          chal_nxt = lfsr_r;
          pend_addr_nxt = i_cmd.addr;
          pend_data_nxt = i_cmd.data;
          tmo_nxt = '0;
        end else if (wr || (rd && i_cmd.addr != OFS_CHALLENGE_CODE)) begin
          // Reading the challenge itself is part of the sequence
          sec_nxt = SEC_IDLE;
          chal_nxt = '0;
          apply_en = wr;
        end else if (tmo_r >= TMO_W'(TIMEOUT_CYCLES - 1)) begin
          sec_nxt = SEC_IDLE;
          chal_nxt = '0;
        end
      end
      default: begin
        sec_nxt = SEC_IDLE;
        chal_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sec_r <= SEC_IDLE;
      chal_r <= '0;
      pend_addr_r <= '0;
      pend_data_r <= '0;
      tmo_r <= '0;
      lfsr_r <= LFSR_SEED;
    end else begin
      sec_r <= sec_nxt;
      chal_r <= chal_nxt;
      pend_addr_r <= pend_addr_nxt;
      pend_data_r <= pend_data_nxt;
      tmo_r <= tmo_nxt;
      lfsr_r <= lfsr_nxt;
    end
  end

  // ==========================================================
  // Register file; hardware set wins over a same-cycle clear
  always_comb begin
    logic [BUCK_FLAG_W-1:0] clr_b;
    logic [LINEAR_W-1:0] clr_l;
    logic [FAILSAFE_W-1:0] clr_f;
    clr_b = '0;
    clr_l = '0;
    clr_f = '0;
    ctrl_nxt = ctrl_r;
    buck_mon_nxt = buck_mon_r;
    lin_mon_nxt = lin_mon_r;
    go_nxt = 1'b0;
    if (apply_en) begin
      case (apply_addr)
        OFS_BUCK_SELFTEST_UNDERVOLT_FLAGS: clr_b = apply_data[BUCK_FLAG_W-1:0];
        OFS_LINEAR_SELFTEST_UNDERVOLT_FLAGS: clr_l = apply_data[LINEAR_W-1:0];
        OFS_SELFTEST_TRIGGER: go_nxt = apply_data[SELFTEST_GO_BIT];
        OFS_SAFE_OUTPUT_FAULT_FLAGS: clr_f = apply_data[FAILSAFE_W-1:0];
        OFS_SAFETY_MONITOR_CONTROL: ctrl_nxt = apply_data[CTRL_W-1:0];
        OFS_BUCK_MONITOR_ENABLES: buck_mon_nxt = apply_data[BUCK_MON_W-1:0];
        OFS_LINEAR_MONITOR_ENABLES: lin_mon_nxt = apply_data[LINEAR_W-1:0];
        default: begin
        end
      endcase
    end
    buck_flags_nxt = (buck_flags_r & ~clr_b) | s_buck;
    lin_flags_nxt = (lin_flags_r & ~clr_l) | s_lin;
    fs_flags_nxt = (fs_flags_r & ~clr_f) | s_fs;
  end

  // ==========================================================
  // Read path: data one cycle after the read command
  always_comb begin
    rvalid_nxt = rd;
    rdata_nxt = rdata_r;
    if (rd) begin
      case (i_cmd.addr)
        OFS_BUCK_SELFTEST_UNDERVOLT_FLAGS: rdata_nxt = 8'(buck_flags_r);
        OFS_LINEAR_SELFTEST_UNDERVOLT_FLAGS: rdata_nxt = 8'(lin_flags_r);
        OFS_SAFE_OUTPUT_FAULT_FLAGS: rdata_nxt = 8'(fs_flags_r);
        OFS_SAFETY_MONITOR_CONTROL: rdata_nxt = 8'(ctrl_r);
        OFS_BUCK_MONITOR_ENABLES: rdata_nxt = 8'(buck_mon_r);
        OFS_LINEAR_MONITOR_ENABLES: rdata_nxt = 8'(lin_mon_r);
        OFS_CHALLENGE_CODE: rdata_nxt = chal_r;
        // Trigger and response are write-only; response clears on compare
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      buck_flags_r <= '0;
      lin_flags_r <= '0;
      fs_flags_r <= '0;
      ctrl_r <= CTRL_RESET;
      buck_mon_r <= BUCK_MON_RESET;
      lin_mon_r <= LINEAR_MON_RESET;
      go_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      buck_flags_r <= buck_flags_nxt;
      lin_flags_r <= lin_flags_nxt;
      fs_flags_r <= fs_flags_nxt;
      ctrl_r <= ctrl_nxt;
      buck_mon_r <= buck_mon_nxt;
      lin_mon_r <= lin_mon_nxt;
      go_r <= go_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // Gated events and enables, registered so outputs are glitch free
  ssrb_events_type ev_r, ev_nxt;
  ssrb_enables_type en_r, en_nxt;

  always_comb begin
    ev_nxt.thermal_int = ctrl_r[CTL_THERMAL_BIT] && s_talarm;
    ev_nxt.thermal_shutdown = ctrl_r[CTL_THERMAL_BIT] && s_ttrip;
    ev_nxt.ovlo_int = ctrl_r[CTL_OVLO_BIT] && s_ov;
    ev_nxt.ovlo_shutdown = ctrl_r[CTL_OVLO_BIT] && ctrl_r[CTL_OVSD_BIT] && s_ov;
    en_nxt.timer_run = ctrl_r[CTL_TIMER_BIT] &&
                       (!s_stby || ctrl_r[CTL_TIMER_STBY_BIT]);
    en_nxt.kick_watch = ctrl_r[CTL_TIMER_BIT] &&
                        (!s_stby || ctrl_r[CTL_KICK_STBY_BIT]);
    en_nxt.buck_monitor_on = buck_mon_r;
    en_nxt.linear_monitor_on = lin_mon_r;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ev_r <= '0;
      en_r <= '0;
    end else begin
      ev_r <= ev_nxt;
      en_r <= en_nxt;
    end
  end

  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_selftest_go = go_r;
  assign o_events = ev_r;
  assign o_enables = en_r;

endmodule

// ### rtl/ssrb_pkg.sv
// Constants, field layouts and carrier types for the safety register bank.
// Assumes an 8-bit register command port fed by the device's serial front end.
package ssrb_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_BUCK_SELFTEST_UNDERVOLT_FLAGS = 8'h00;
  localparam logic [7:0] OFS_LINEAR_SELFTEST_UNDERVOLT_FLAGS = 8'h01;
  localparam logic [7:0] OFS_SELFTEST_TRIGGER = 8'h02;
  localparam logic [7:0] OFS_SAFE_OUTPUT_FAULT_FLAGS = 8'h03;
  localparam logic [7:0] OFS_SAFETY_MONITOR_CONTROL = 8'h04;
  localparam logic [7:0] OFS_BUCK_MONITOR_ENABLES = 8'h05;
  localparam logic [7:0] OFS_LINEAR_MONITOR_ENABLES = 8'h06;
  localparam logic [7:0] OFS_CHALLENGE_CODE = 8'h07;
  localparam logic [7:0] OFS_CHALLENGE_RESPONSE = 8'h08;

  // ==========================================================
  // Field widths and positions
  localparam int BUCK_FLAG_W = 4;   // buck 2, 5, 6, 7 in bits 0..3
  localparam int LINEAR_W = 3;      // linear 1..3 in bits 0..2
  localparam int FAILSAFE_W = 5;    // assert, soft, kick, count, hard in bits 0..4
  localparam int BUCK_MON_W = 5;    // buck 1, 2, 5, 6, 7 in bits 0..4
  localparam int CTRL_W = 7;
  localparam int SELFTEST_GO_BIT = 0;
  localparam int CTL_THERMAL_BIT = 0;
  localparam int CTL_OVLO_BIT = 1;
  localparam int CTL_OVSD_BIT = 2;
  localparam int CTL_TIMER_BIT = 3;
  localparam int CTL_TIMER_STBY_BIT = 4;
  localparam int CTL_KICK_STBY_BIT = 5;
  localparam int CTL_SECURE_BIT = 6;

  // ==========================================================
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h7F;
  localparam logic [BUCK_MON_W-1:0] BUCK_MON_RESET = 5'h1F;
  localparam logic [LINEAR_W-1:0] LINEAR_MON_RESET = 3'h7;
  localparam logic [7:0] LFSR_SEED = 8'hA5;
  localparam logic [7:0] LFSR_TAPS = 8'hB8;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int SECURE_TIMEOUT_MS = 10;
  localparam int SECURE_TIMEOUT_CYCLES = SECURE_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int TMO_W = 24;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] data;
  } ssrb_cmd_type;

  typedef struct packed {
    logic thermal_int;
    logic thermal_shutdown;
    logic ovlo_int;
    logic ovlo_shutdown;
  } ssrb_events_type;

  typedef struct packed {
    logic timer_run;
    logic kick_watch;
    logic [BUCK_MON_W-1:0] buck_monitor_on;
    logic [LINEAR_W-1:0] linear_monitor_on;
  } ssrb_enables_type;

  typedef enum logic {SEC_IDLE, SEC_WAIT} ssrb_sec_type;

endpackage

// ### sim/ssrb_bank_asserts.sv
// Checker for the command port and control outputs of the register bank.
// Assumes it is bound to every bank instance and sees only its ports.
`timescale 1ns/10ps
module ssrb_bank_asserts
  import ssrb_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = SECURE_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Command port and controls
  input wire ssrb_cmd_type i_cmd,
  input wire logic o_rvalid,
  input wire logic [7:0] o_rdata,
  input wire logic o_selftest_go,
  input wire ssrb_enables_type o_enables
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic rd_cmd, wr_cmd;
  assign rd_cmd = i_cmd.valid && !i_cmd.write;
  assign wr_cmd = i_cmd.valid && i_cmd.write;

  // ==========
  // Assertions
  a_read_answered: assert property (rd_cmd |=> o_rvalid)
    else $error("read command got no answer");
  a_rvalid_cause: assert property (o_rvalid |-> $past(rd_cmd))
    else $error("read strobe without a read");
  a_response_reads_zero: assert property (
    rd_cmd && i_cmd.addr == OFS_CHALLENGE_RESPONSE |=> o_rdata == 8'h00)
    else $error("response register not clear");
  a_trigger_reads_zero: assert property (
    rd_cmd && i_cmd.addr == OFS_SELFTEST_TRIGGER |=> o_rdata == 8'h00)
    else $error("trigger register not self clearing");
  a_go_one_pulse: assert property (o_selftest_go |=> !o_selftest_go)
    else $error("selftest start longer than one cycle");
  a_go_needs_write: assert property (o_selftest_go |-> $past(wr_cmd))
    else $error("selftest start without a write");
  // Latency of one to three edges tolerated; the gap between writes keeps it exact enough
  a_buck_mon_cause: assert property ($past(i_resetn, 3) &&
    $changed(o_enables.buck_monitor_on) |-> $past(wr_cmd) || $past(wr_cmd, 2) || $past(wr_cmd, 3))
    else $error("buck monitor enables moved without a write");
  a_linear_mon_cause: assert property ($past(i_resetn, 3) &&
    $changed(o_enables.linear_monitor_on) |-> $past(wr_cmd) || $past(wr_cmd, 2) || $past(wr_cmd, 3))
    else $error("linear monitor enables moved without a write");

  c_read: cover property (rd_cmd ##1 o_rvalid);
  c_go: cover property (o_selftest_go);
  c_linear_mon: cover property ($changed(o_enables.linear_monitor_on));
endmodule

bind ssrb_bank ssrb_bank_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_ssrb_bank_asserts (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_cmd(i_cmd), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
  .o_selftest_go(o_selftest_go), .o_enables(o_enables));

// ### sim/ssrb_bank_tb_top.sv
// Self-checking testbench for the safety register bank.
// Assumes the host model drives all commands; timeout shortened to TMO cycles.
`timescale 1ns/10ps
module ssrb_bank_tb_top
  import ssrb_pkg::*;
;
  localparam int TMO = 50;
  localparam logic [7:0] CT [5] = '{8'h3F, 8'h37, 8'h3F, 8'h2F, 8'h1F};
  localparam logic [4:0] SB = 5'h1C;
  localparam logic [4:0] TR = 5'h15;
  localparam logic [4:0] KW = 5'h0C;
  localparam logic [7:0] EC [4] = '{8'h3F, 8'h3B, 8'h39, 8'h38};
  localparam logic [3:0] EE [4] = '{4'hF, 4'hE, 4'hC, 4'h0};
  logic clk, resetn, rvalid, go, ok;
  logic [7:0] rdata, q, code;
  logic [3:0] buck_low, mon;
  logic [2:0] lin_low;
  logic [4:0] fs_fault;
  ssrb_cmd_type cmd;
  ssrb_events_type ev;
  ssrb_enables_type en;
  int err_total, checked;

  ssrb_bank #(.TIMEOUT_CYCLES(TMO)) i_ssrb_bank (
    .i_clk(clk), .i_resetn(resetn), .i_cmd(cmd), .o_rvalid(rvalid), .o_rdata(rdata),
    .i_selftest_buck_low(buck_low), .i_selftest_linear_low(lin_low),
    .i_failsafe_fault(fs_fault), .i_thermal_alarm(mon[3]), .i_thermal_trip(mon[2]),
    .i_main_supply_overvolt(mon[1]), .i_standby(mon[0]), .o_selftest_go(go),
    .o_events(ev), .o_enables(en));
  ssrb_host_model i_ssrb_host_model (
    .i_clk(clk), .o_cmd(cmd), .i_rvalid(rvalid), .i_rdata(rdata));

  // ==========
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_ssrb_host_model.xfer(1'b1, a, d, q, ok);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_ssrb_host_model.xfer(1'b0, a, 8'h00, q, ok);
    chk({7'h00, ok}, 8'h01, "read strobe");
    chk(q, exp, "read data");
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========
  // Clock, hang guard and sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100_000;
    err_total++;
    print_verdict();
  end
  initial begin
    resetn = 1'b0;
    buck_low = '0;
    lin_low = '0;
    fs_fault = '0;
    mon = '0;
    err_total = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    #1 resetn = 1'b1;
    rd(OFS_SAFETY_MONITOR_CONTROL, {1'b0, CTRL_RESET});
    rd(OFS_BUCK_MONITOR_ENABLES, {3'h0, BUCK_MON_RESET});
    rd(OFS_LINEAR_MONITOR_ENABLES, {5'h00, LINEAR_MON_RESET});
    for (int i = 0; i < 4; i++) begin
      rd(8'(i), 8'h00);
    end
    rd(OFS_CHALLENGE_CODE, 8'h00);
    rd(OFS_CHALLENGE_RESPONSE, 8'h00);
    rd(8'h2A, 8'h00);
    $display("reset test done");
    i_ssrb_host_model.sec_wr(OFS_SAFETY_MONITOR_CONTROL, 8'h3F, 1'b0);
    rd(OFS_SAFETY_MONITOR_CONTROL, 8'h7F);
    rd(OFS_CHALLENGE_CODE, 8'h00);
    wr(OFS_BUCK_MONITOR_ENABLES, 8'h00);
    wr(8'h30, 8'h55);
    rd(OFS_CHALLENGE_CODE, 8'h00);
    rd(OFS_BUCK_MONITOR_ENABLES, 8'h1F);
    wr(OFS_LINEAR_MONITOR_ENABLES, 8'h00);
    i_ssrb_host_model.xfer(1'b0, OFS_CHALLENGE_CODE, 8'h00, code, ok);
    chk({7'h00, code != 8'h00}, 8'h01, "challenge loaded");
    wait_clk(TMO + 5);
    rd(OFS_CHALLENGE_CODE, 8'h00);
    wr(OFS_CHALLENGE_RESPONSE, code);
    rd(OFS_LINEAR_MONITOR_ENABLES, 8'h07);
    $display("secure refusal test done");
    i_ssrb_host_model.sec_wr(OFS_SAFETY_MONITOR_CONTROL, 8'h3F, 1'b1);
    rd(OFS_SAFETY_MONITOR_CONTROL, 8'h3F);
    wr(OFS_BUCK_MONITOR_ENABLES, 8'h0A);
    wr(OFS_LINEAR_MONITOR_ENABLES, 8'h05);
    wait_clk(2);
    chk({3'h0, en.buck_monitor_on}, 8'h0A, "buck monitors");
    chk({5'h00, en.linear_monitor_on}, 8'h05, "linear monitors");
    for (int i = 0; i < 5; i++) begin
      mon[0] = SB[i];
      wr(OFS_SAFETY_MONITOR_CONTROL, CT[i]);
      wait_clk(8);
      chk({7'h00, en.timer_run}, {7'h00, TR[i]}, "timer run");
      if (SB[i]) begin
        chk({7'h00, en.kick_watch}, {7'h00, KW[i]}, "kick watch");
      end
    end
    mon = 4'hE;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_SAFETY_MONITOR_CONTROL, EC[i]);
      wait_clk(8);
      chk({4'h0, ev}, {4'h0, EE[i]}, "events");
    end
    mon = 4'h0;
    $display("control test done");
    buck_low = 4'hF;
    lin_low = 3'h7;
    fs_fault = 5'h1F;
    wait_clk(8);
    buck_low = '0;
    lin_low = '0;
    fs_fault = '0;
    wait_clk(8);
    wr(OFS_SAFE_OUTPUT_FAULT_FLAGS, 8'h00);
    rd(OFS_SAFE_OUTPUT_FAULT_FLAGS, 8'h1F);
    wr(OFS_SAFE_OUTPUT_FAULT_FLAGS, 8'h01);
    rd(OFS_SAFE_OUTPUT_FAULT_FLAGS, 8'h1E);
    // Source still high while cleared: the hardware set must win
    fs_fault = 5'h01;
    wait_clk(8);
    wr(OFS_SAFE_OUTPUT_FAULT_FLAGS, 8'h01);
    rd(OFS_SAFE_OUTPUT_FAULT_FLAGS, 8'h1F);
    fs_fault = '0;
    rd(OFS_BUCK_SELFTEST_UNDERVOLT_FLAGS, 8'h0F);
    wr(OFS_BUCK_SELFTEST_UNDERVOLT_FLAGS, 8'h0F);
    rd(OFS_BUCK_SELFTEST_UNDERVOLT_FLAGS, 8'h00);
    wr(OFS_LINEAR_SELFTEST_UNDERVOLT_FLAGS, 8'h05);
    rd(OFS_LINEAR_SELFTEST_UNDERVOLT_FLAGS, 8'h02);
    wr(OFS_SELFTEST_TRIGGER, 8'h00);
    chk({7'h00, go}, 8'h00, "selftest idle");
    wr(OFS_SELFTEST_TRIGGER, 8'h01);
    chk({7'h00, go}, 8'h01, "selftest start");
    wait_clk(1);
    chk({7'h00, go}, 8'h00, "selftest pulse end");
    $display("flag test done");
    print_verdict();
  end
endmodule

// ### sim/ssrb_host_model.sv
// Host-side command source for the safety register bank.
// Assumes the bank takes a command on the rising edge of i_clk.
`timescale 1ns/10ps
module ssrb_host_model
  import ssrb_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Command port
  output ssrb_cmd_type o_cmd,
  input wire logic i_rvalid,
  input wire logic [7:0] i_rdata
);
  // ==========
  // Bus cycles
  initial o_cmd = '0;

  // One idle edge between commands; released fields show the inverse, not stale values
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
    @(posedge i_clk);
    #1 o_cmd = {1'b1, w, a, d};
    @(posedge i_clk);
    #1 o_cmd = {1'b0, ~w, ~a, ~d};
    ok = i_rvalid;
    q = i_rdata;
  endtask

  task automatic sec_wr(input logic [7:0] a, input logic [7:0] d, input logic good);
    logic [7:0] q;
    logic ok;
    xfer(1'b1, a, d, q, ok);
    xfer(1'b0, OFS_CHALLENGE_CODE, 8'h00, q, ok);
    xfer(1'b1, OFS_CHALLENGE_RESPONSE, good ? q : ~q, q, ok);
  endtask
endmodule
